// [sram_port_pkg.sv]
// Constants shared by the per-port control of the banked dual-port memory.
// Assumes the bank array itself lives outside and reads combinationally.
//
// Operation
// - Access only when primary select low and secondary select high.
// - Write stores only lanes whose enable is low; upper 17:9, lower 8:0.
// - Read drives only enabled lanes with drive enable low; others float.
// - Any lane combination is accepted, including none at all.
// - Drive enable high floats data outputs at once, without the clock.
// - Address strobe low loads external address, regardless of selects.
// - Strobe high and advance low increments counter, regardless of selects.
// - Strobe and advance both high hold counter; external address ignored.
// - Restore low returns counter to last strobe load, overriding all.
// - Restore address unknown at power-up; master should load one first.
// - Every strobe load also overwrites the stored restore address.
// - Advancing past word FFFh gives word 0h of the next bank.
// - Advancing past last word of bank 63 wraps to bank 0 word 0.
// - Flow-through read data in access cycle; pipelined one cycle later.
`default_nettype none

package sram_port_pkg;
  localparam int LANE_W = 9;
  localparam int DATA_W = 2 * LANE_W;
  localparam int WORD_W = 12;
  localparam int BANK_W = 6;
  localparam int ADDR_W = BANK_W + WORD_W;
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 18'h00001;
  localparam logic [1:0] LANES_NONE = 2'h0;
  localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
  localparam int UPPER_LANE = 1;
  localparam int LOWER_LANE = 0;
endpackage

`default_nettype wire

// [sram_port_ctrl.sv]
// Per-port synchronous control: selects, lane enables, burst counter and
// the flow-through or pipelined read path of one memory port.
// Assumes the bank array answers mem_rdata_i combinationally from
// mem_addr_o, and that the bus master runs on core_clk_i.
`timescale 1ns/1ps
`default_nettype none

module sram_port_ctrl (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Static configuration
  input wire logic pipeline_select_i,
  // Access control
  input wire logic primary_select_n_i,
  input wire logic secondary_select_i,
  input wire logic read_not_write_i,
  input wire logic upper_lane_enable_n_i,
  input wire logic lower_lane_enable_n_i,
  input wire logic output_drive_enable_n_i,
  // Address and counter control
  input wire logic address_load_strobe_n_i,
  input wire logic counter_advance_n_i,
  input wire logic counter_restore_n_i,
  input wire logic [sram_port_pkg::BANK_W-1:0] bank_select_i,
  input wire logic [sram_port_pkg::WORD_W-1:0] word_addr_i,
  // Data pins, split three ways
  input wire logic [sram_port_pkg::DATA_W-1:0] dq_i,
  output logic [sram_port_pkg::DATA_W-1:0] dq_o,
  output logic [sram_port_pkg::DATA_W-1:0] dq_oe_o,
  // Bank array side
  output logic [sram_port_pkg::ADDR_W-1:0] mem_addr_o,
  output logic mem_we_o,
  output logic [1:0] mem_lane_we_o,
  output logic [sram_port_pkg::DATA_W-1:0] mem_wdata_o,
  input wire logic [sram_port_pkg::DATA_W-1:0] mem_rdata_i,
  // Status
  output logic standby_o
);
  import sram_port_pkg::*;

  function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] lanes);
    lane_mask = {{LANE_W{lanes[UPPER_LANE]}}, {LANE_W{lanes[LOWER_LANE]}}};
  endfunction

  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;
  logic [ADDR_W-1:0] restore_reg;
  logic [ADDR_W-1:0] restore_next;
  logic [1:0] wr_lane_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [1:0] rd_lane_reg;
  logic [1:0] stage_lane_reg;
  logic [DATA_W-1:0] stage_data_reg;
  logic [1:0] drive_reg;
  logic [1:0] drive_next;
  logic [DATA_W-1:0] dq_reg;
  logic [DATA_W-1:0] dq_next;
  logic standby_reg;

  wire port_selected = !primary_select_n_i && secondary_select_i;
  wire [1:0] lanes_on = {!upper_lane_enable_n_i, !lower_lane_enable_n_i};
  wire wr_fire = port_selected && !read_not_write_i;
  wire rd_fire = port_selected && read_not_write_i;
  wire [ADDR_W-1:0] ext_addr = {bank_select_i, word_addr_i};
  wire do_restore = !counter_restore_n_i;
  wire do_load = counter_restore_n_i && !address_load_strobe_n_i;
  wire do_advance = counter_restore_n_i && address_load_strobe_n_i
    && !counter_advance_n_i;

  // Restore beats load beats advance; a plain 18-bit add carries from the
  // word field into the bank field and wraps bank 63 back to bank 0.
  assign addr_next = do_restore ? restore_reg :
    do_load ? ext_addr :
    do_advance ? addr_reg + ADDR_STEP :
    addr_reg;
  assign restore_next = do_load ? ext_addr : restore_reg;

  // Only the static mode input picks one or two read stages.
  assign drive_next = pipeline_select_i ? stage_lane_reg : rd_lane_reg;
  assign dq_next = pipeline_select_i ? stage_data_reg : mem_rdata_i;

  // Counter registers take no part in selection, so they run every edge.
  // Restore value is cleared by reset only to keep it defined in simulation;
  // a master must still load it before relying on restore.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      addr_reg <= ADDR_RST;
      restore_reg <= ADDR_RST;
    end else begin
      addr_reg <= addr_next;
      restore_reg <= restore_next;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_lane_reg <= LANES_NONE;
      rd_lane_reg <= LANES_NONE;
      wdata_reg <= DATA_RST;
      standby_reg <= 1'b1;
    end else begin
      wr_lane_reg <= wr_fire ? lanes_on : LANES_NONE;
      rd_lane_reg <= rd_fire ? lanes_on : LANES_NONE;
      wdata_reg <= dq_i;
      standby_reg <= !port_selected;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      stage_lane_reg <= LANES_NONE;
      stage_data_reg <= DATA_RST;
      drive_reg <= LANES_NONE;
      dq_reg <= DATA_RST;
    end else begin
      stage_lane_reg <= rd_lane_reg;
      stage_data_reg <= mem_rdata_i;
      drive_reg <= drive_next;
      dq_reg <= dq_next;
    end
  end

  assign mem_addr_o = addr_reg;
  assign mem_lane_we_o = wr_lane_reg;
  assign mem_we_o = |wr_lane_reg;
  assign mem_wdata_o = wdata_reg;
  assign dq_o = dq_reg;
  assign standby_o = standby_reg;
  // Drive enable bypasses every register so it floats the bus at once.
  assign dq_oe_o = output_drive_enable_n_i ? DATA_RST
    : lane_mask(drive_reg);

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  AST_DESEL_IDLE: assert property (
    !port_selected |=> !mem_we_o && standby_o)
    else $error("deselected port still accessed");

  AST_LANE_WRITE: assert property (
    wr_fire |=> mem_lane_we_o == $past(lanes_on)
      && mem_wdata_o == $past(dq_i))
    else $error("written lanes differ from enables");

  AST_FLOW_DRIVE: assert property (
    (rd_fire && !pipeline_select_i) ##1 !pipeline_select_i
      |=> drive_reg == $past(lanes_on, 2))
    else $error("flow read drives wrong lanes");

  // The read lanes of this access sit in rd_lane_reg one edge later,
  // which is what drive_next passes on in flow-through mode.
  AST_NO_LANE: assert property (
    port_selected && lanes_on == LANES_NONE
      |=> mem_lane_we_o == LANES_NONE
        && (drive_next == LANES_NONE || pipeline_select_i))
    else $error("no-lane access touched a lane");

  AST_NO_LANE_WRITE: assert property (
    wr_fire && lanes_on == LANES_NONE |=> !mem_we_o)
    else $error("no-lane write still strobed the array");

  AST_OE_FLOAT: assert property (
    output_drive_enable_n_i |-> dq_oe_o == DATA_RST)
    else $error("data driven with drive enable high");

  AST_LOAD: assert property (
    do_load |=> mem_addr_o == $past(ext_addr))
    else $error("strobe did not load address");

  AST_ADVANCE: assert property (
    do_advance |=> mem_addr_o == $past(addr_reg) + ADDR_STEP)
    else $error("counter did not advance by one");

  AST_HOLD: assert property (
    counter_restore_n_i && address_load_strobe_n_i && counter_advance_n_i
      |=> $stable(mem_addr_o))
    else $error("held counter moved");

  AST_RESTORE: assert property (
    do_load ##1 (counter_restore_n_i && address_load_strobe_n_i)[*2]
      ##1 do_restore |=> mem_addr_o == $past(ext_addr, 4))
    else $error("restore missed last loaded address");

  AST_RESTORE_SAVE: assert property (
    do_load |=> restore_reg == $past(ext_addr))
    else $error("load did not update restore address");

  AST_BANK_CARRY: assert property (
    do_advance && addr_reg[WORD_W-1:0] == 12'hFFF
      |=> mem_addr_o[WORD_W-1:0] == 12'h000
        && mem_addr_o[ADDR_W-1:WORD_W] == $past(addr_reg[ADDR_W-1:WORD_W])
          + 6'h01)
    else $error("counter did not carry into next bank");

  AST_TOP_WRAP: assert property (
    do_advance && addr_reg == 18'h3FFFF |=> mem_addr_o == ADDR_RST)
    else $error("counter did not wrap to bank zero");

  AST_PIPE_DRIVE: assert property (
    (rd_fire && pipeline_select_i) ##1 pipeline_select_i[*2]
      |=> drive_reg == $past(lanes_on, 3))
    else $error("pipelined read drives wrong lanes");

  // Reset leaves a quiet, defined port behind it.
  AST_RESET_STATE: assert property (
    $past(rst_i) |-> mem_addr_o == ADDR_RST && restore_reg == ADDR_RST
      && !mem_we_o && standby_o && drive_reg == LANES_NONE
      && dq_o == DATA_RST)
    else $error("port not quiet after reset");

  AST_DESEL_NO_READ: assert property (
    !port_selected |=> rd_lane_reg == LANES_NONE)
    else $error("deselected port armed a read");

  AST_SEL_AWAKE: assert property (
    port_selected |=> !standby_o)
    else $error("selected port left in standby");

  AST_NO_WRITE: assert property (
    !wr_fire |=> !mem_we_o)
    else $error("array written without a write access");

  AST_UPPER_WRITE: assert property (
    wr_fire && lanes_on == 2'h2 |=> mem_lane_we_o == 2'h2)
    else $error("upper-only write touched lower lane");

  AST_READ_LANES: assert property (
    rd_fire |=> rd_lane_reg == $past(lanes_on))
    else $error("read lanes not captured");

  AST_WRITE_NO_DRIVE: assert property (
    (wr_fire && !pipeline_select_i) ##1 !pipeline_select_i
      |=> drive_reg == LANES_NONE)
    else $error("write cycle drove the data pins");

  AST_LOWER_READ: assert property (
    (rd_fire && lanes_on == 2'h1 && !pipeline_select_i)
      ##1 !pipeline_select_i
      |=> output_drive_enable_n_i
        || dq_oe_o == {{LANE_W{1'b0}}, {LANE_W{1'b1}}})
    else $error("lower-only read enabled the upper lane");

  AST_OE_PASS: assert property (
    !output_drive_enable_n_i && drive_reg == 2'h3
      |-> dq_oe_o == {DATA_W{1'b1}})
    else $error("drive enable low blocked both lanes");

  AST_LOAD_BANK: assert property (
    do_load |=> mem_addr_o[ADDR_W-1:WORD_W] == $past(bank_select_i))
    else $error("bank field not loaded from bank select");

  AST_ADV_DESEL: assert property (
    do_advance && !port_selected
      |=> mem_addr_o == $past(addr_reg) + ADDR_STEP)
    else $error("deselected port did not advance");

  AST_WORD_STEP: assert property (
    do_advance && addr_reg[WORD_W-1:0] != 12'hFFF
      |=> mem_addr_o[ADDR_W-1:WORD_W] == $past(addr_reg[ADDR_W-1:WORD_W]))
    else $error("bank changed inside a bank");

  AST_RESTORE_NEAR: assert property (
    do_load ##1 (counter_restore_n_i && address_load_strobe_n_i)
      ##1 do_restore |=> mem_addr_o == $past(ext_addr, 3))
    else $error("early restore missed last loaded address");

  AST_RESTORE_WINS: assert property (
    do_restore |=> mem_addr_o == $past(restore_reg))
    else $error("restore did not override strobe and advance");

  // A strobe under restore must not move the saved address.
  AST_RESTORE_NO_SAVE: assert property (
    do_restore |=> restore_reg == $past(restore_reg))
    else $error("restore cycle changed saved address");

  AST_RESTORE_KEEP: assert property (
    !do_load |=> $stable(restore_reg))
    else $error("saved address moved without a load");

  AST_FLOW_DATA: assert property (
    !pipeline_select_i |=> dq_o == $past(mem_rdata_i))
    else $error("flow-through data not from access cycle");

  AST_PIPE_DATA: assert property (
    pipeline_select_i ##1 pipeline_select_i
      |=> dq_o == $past(mem_rdata_i, 2))
    else $error("pipelined data not one cycle late");

endmodule // sram_port_ctrl

`default_nettype wire

// [sram_bank_model.sv]
// Behavioural bank array seen by one port control.
// Assumes registered write strobes and a combinational read.
`timescale 1ns/1ps
`default_nettype none
module sram_bank_model
  import sram_port_pkg::*;
(
  // Port side
  input wire logic core_clk_i,
  input wire logic [ADDR_W-1:0] mem_addr_i,
  input wire logic mem_we_i,
  input wire logic [1:0] mem_lane_we_i,
  input wire logic [DATA_W-1:0] mem_wdata_i,
  output logic [DATA_W-1:0] mem_rdata_o
);
  // Unwritten words read as ones, so a stray lane write shows up
  logic [DATA_W-1:0] word_reg [0:(1<<ADDR_W)-1] = '{default: '1};
  // Serves a single port, so no second port can share its bank
  assign mem_rdata_o = word_reg[mem_addr_i];
  always @(posedge core_clk_i) begin
    if (mem_we_i && mem_lane_we_i[1])
      word_reg[mem_addr_i][17:9] <= mem_wdata_i[17:9];
    if (mem_we_i && mem_lane_we_i[0])
      word_reg[mem_addr_i][8:0] <= mem_wdata_i[8:0];
  end
endmodule // sram_bank_model
`default_nettype wire

// [dual_port_bank_sram_port_control_tb_top.sv]
// Directed bench for one port control with its bank array model.
// Assumes the bench acts as the bus master on the port clock.
`timescale 1ns/1ps
`default_nettype none
module dual_port_bank_sram_port_control_tb_top;
  import sram_port_pkg::*;
  localparam logic [2:0] LD = 3'h3, ADV = 3'h5, HLD = 3'h7, RPT = 3'h6;
  localparam logic [17:0] D1 = 18'h2A5C3, D2 = 18'h15A3C, D3 = 18'h3C0F1;
  logic clk = 1'b0, rst = 1'b1, pipe = 1'b0, sel = 1'b0, rnw = 1'b1;
  logic oe_n = 1'b0, we, stby;
  logic [1:0] lane_n = 2'h3, lwe;
  logic [2:0] ctl = HLD;
  logic [17:0] a = 18'h00000, d = 18'h00000, dq, oe, ma, wd, rd;
  int fail_count = 0, checks_done = 0;
  always #20 clk = ~clk;
  sram_port_ctrl u_sram_port_ctrl (.core_clk_i(clk), .rst_i(rst),
    .pipeline_select_i(pipe), .primary_select_n_i(~sel),
    .secondary_select_i(sel), .read_not_write_i(rnw),
    .upper_lane_enable_n_i(lane_n[1]), .lower_lane_enable_n_i(lane_n[0]),
    .output_drive_enable_n_i(oe_n), .address_load_strobe_n_i(ctl[2]),
    .counter_advance_n_i(ctl[1]), .counter_restore_n_i(ctl[0]),
    .bank_select_i(a[17:12]), .word_addr_i(a[11:0]), .dq_i(d), .dq_o(dq),
    .dq_oe_o(oe), .mem_addr_o(ma), .mem_we_o(we), .mem_lane_we_o(lwe),
    .mem_wdata_o(wd), .mem_rdata_i(rd), .standby_o(stby));
  sram_bank_model u_sram_bank_model (.core_clk_i(clk), .mem_addr_i(ma),
    .mem_we_i(we), .mem_lane_we_i(lwe), .mem_wdata_i(wd), .mem_rdata_o(rd));
  // Results of one step show after the following step returns
  task automatic step(input logic s, r, input logic [1:0] l,
                      input logic [2:0] c, input logic [17:0] ad, dd);
    @(posedge clk);
    sel <= s;
    rnw <= r;
    lane_n <= l;
    ctl <= c;
    a <= ad;
    d <= dd;
    @(negedge clk);
  endtask
  task automatic cmp(input string n, input logic [17:0] e, g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic do_reset(input logic p);
    @(posedge clk);
    rst <= 1'b1;
    pipe <= p;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
  endtask
  initial begin
    do_reset(1'b0);
    step(1, 0, 2'h0, LD, 18'h00FFF, D1);
    step(1, 0, 2'h1, ADV, 18'h00000, D2);
    cmp("addr", 18'h00FFF, ma);
    cmp("lane_we", 18'h00003, {16'h0, lwe});
    cmp("wdata", D1, wd);
    step(0, 0, 2'h0, RPT, 18'h00000, D3);
    cmp("addr", 18'h01000, ma);
    cmp("lane_we", 18'h00002, {16'h0, lwe});
    step(1, 1, 2'h0, HLD, 18'h12345, 18'h00000);
    cmp("addr", 18'h00FFF, ma);
    cmp("we", 18'h00000, {17'h0, we});
    cmp("standby", 18'h00001, {17'h0, stby});
    step(1, 1, 2'h2, ADV, 18'h00000, 18'h00000);
    cmp("addr", 18'h00FFF, ma);
    step(0, 1, 2'h3, HLD, 18'h00000, 18'h00000);
    cmp("rdata", D1, dq);
    cmp("oe", 18'h3FFFF, oe);
    cmp("addr", 18'h01000, ma);
    step(1, 1, 2'h3, LD, 18'h3FFFF, 18'h00000);
    cmp("lower", 18'h001FF, dq & oe);
    step(0, 1, 2'h3, ADV, 18'h00000, 18'h00000);
    cmp("oe", 18'h00000, oe);
    cmp("addr", 18'h3FFFF, ma);
    step(0, 1, 2'h3, HLD, 18'h00000, 18'h00000);
    cmp("addr", 18'h00000, ma);
    do_reset(1'b1);
    step(1, 0, 2'h0, LD, 18'h2ABCD, D3);
    step(1, 1, 2'h0, HLD, 18'h00000, 18'h00000);
    step(0, 1, 2'h3, HLD, 18'h00000, 18'h00000);
    step(0, 1, 2'h3, HLD, 18'h00000, 18'h00000);
    cmp("oe", 18'h00000, oe);
    step(0, 1, 2'h3, HLD, 18'h00000, 18'h00000);
    cmp("rdata", D3, dq);
    @(posedge clk);
    oe_n <= 1'b1;
    #1;
    cmp("oe", 18'h00000, oe);
    finish_test;
  end
  initial begin
    repeat (200) @(posedge clk);
    fail_count++;
    finish_test;
  end
endmodule // dual_port_bank_sram_port_control_tb_top
`default_nettype wire
